// *** inc/dof_pkg.sv ***
// Constants, carriers and state layout of the output formatter.
package dof_pkg;

    // Register offsets on the control port.
    localparam logic [2:0] DOF_REG_CTRL = 3'h0;
    localparam logic [2:0] DOF_REG_FORMAT = 3'h1;
    localparam logic [2:0] DOF_REG_DIVIDER = 3'h2;
    localparam logic [2:0] DOF_REG_STATUS = 3'h3;

    // Control register bit positions.
    localparam int DOF_CTRL_SERIAL_EN = 0;
    localparam int DOF_CTRL_CLK_POL = 1;
    localparam int DOF_CTRL_STROBE_POL = 2;
    localparam int DOF_CTRL_PERIOD_POL = 3;
    localparam int DOF_CTRL_MUX = 4;
    localparam int DOF_CTRL_PACKED = 5;

    // Status register bit positions.
    localparam int DOF_STAT_BUSY = 0;
    localparam int DOF_STAT_OVERRUN = 1;

    // Values after reset.
    localparam logic [2:0] DOF_FORMAT_RESET = 3'h0;
    localparam logic [7:0] DOF_DIVIDER_RESET = 8'h01;

    // Output number formats as held in the format register.
    localparam logic [2:0] DOF_FMT_TRUNC8 = 3'h0;
    localparam logic [2:0] DOF_FMT_ROUND16 = 3'h1;
    localparam logic [2:0] DOF_FMT_ROUND24 = 3'h2;
    localparam logic [2:0] DOF_FMT_TRUNC32 = 3'h3;
    localparam logic [2:0] DOF_FMT_FLOAT = 3'h4;

    // Word lengths in bits of each format.
    localparam logic [6:0] DOF_LEN_8 = 7'h08;
    localparam logic [6:0] DOF_LEN_16 = 7'h10;
    localparam logic [6:0] DOF_LEN_24 = 7'h18;
    localparam logic [6:0] DOF_LEN_32 = 7'h20;
    localparam logic [6:0] DOF_LEN_FLOAT = 7'h0c;
    localparam logic [3:0] DOF_EXP_MAX = 4'hf;

    // Serial engine phases.
    typedef enum logic [1:0] {DOF_IDLE, DOF_STROBE, DOF_DATA} dof_phase_e;

    // One complex sample of both channels, full precision.
    typedef struct packed {
        logic [31:0] ia;
        logic [31:0] qa;
        logic [31:0] ib;
        logic [31:0] qb;
    } dof_sample_s;

    // Software configuration.
    typedef struct packed {
        logic serialEnable;
        logic clkPol;
        logic strobePol;
        logic periodPol;
        logic muxMode;
        logic packed_;
        logic [2:0] format;
        logic [7:0] divider;
    } dof_cfg_s;

    // Whole state of the formatter.
    typedef struct packed {
        dof_cfg_s cfg;
        logic overrun;
        logic [15:0] rdData;
        logic [7:0][15:0] seg;
        logic [15:0] parOut;
        dof_phase_e phase;
        logic [7:0] phaseCnt;
        logic [6:0] bitCnt;
        logic [6:0] wordLen;
        logic [1:0] wordsLeft;
        logic firstWord;
        logic [127:0] shiftOne;
        logic [63:0] shiftTwo;
        logic sck;
        logic strobe;
        logic lineOne;
        logic lineTwo;
        logic ready;
    } dof_state_s;

endpackage

// *** design/dof_output_formatter.sv ***
// Output formatter of a two-channel downconverter: number formats, serial and parallel ports.
//
// Behaviour
// - Two's complement 8/16/24/32 bit or 12-bit float.
// - Sample-ready asserts when a new period begins.
// - Serial pins high impedance until enabled.
// - Mux 0 splits channels; mux 1 shares line one.
// - I before Q on the same line.
// - Outputs change on launch edge set by polarity.
// - One-bit strobe, then word MSB first.
// - Unpacked Q follows I without idle bits.
// - Packed sends I and Q under one strobe.
// - Multiplexed second channel follows first immediately.
// - Sample-ready marks the first word of pair.
// - Bit clock is chip clock over divider plus one, over two for divider zero.
// - Float always packed: mI, eI, eQ, mQ.
// - Bit clock stops after the last bit.
// - Segment select picks one of eight segments.
// - Float upper segments 0000/e/m, lower zero.
// - Parallel port driven only while enable low.
// - Parallel offers 8, 16, 24 or full 32 bits.
// - Fixed point justified high, remaining bits zero.
// - Serial enable bit gates the pins, resets zero.
// - Strobe and ready polarity bits, 1 active low.
`timescale 1ns/1ps

module dof_output_formatter
    import dof_pkg::*;
#(
    parameter int SAMPLE_WIDTH = 32
)
(
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic rst,
    // Register port.
    input wire logic [2:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // Decimated samples from the filters.
    input wire logic sampleValid,
    input wire dof_sample_s sampleIn,
    // Serial port.
    output logic serialBitClock,
    output logic serialFrameStrobe,
    output logic serialLineOne,
    output logic serialLineTwo,
    output logic serialPortOe,
    // Period marker.
    output logic outputSamplePeriod,
    // Parallel port.
    input wire logic parallelEnableN,
    input wire logic [2:0] parallelSegmentSelect,
    output logic [15:0] parallelData,
    output logic parallelOe
);

    // Refuse widths that the formatting logic is not built for.
    if (SAMPLE_WIDTH != 32)
    begin : gWidthCheck
        $error("dof_output_formatter supports only 32-bit samples");
    end

    dof_state_s s;
    dof_state_s next_s;

    // Rounds or truncates a sample and justifies it into the upper bits.
    function automatic logic [31:0] fmtFixed(input logic [31:0] x, input logic [2:0] fmt);
        logic [32:0] sum;
        logic [31:0] mask;
        logic [31:0] half;
        fmtFixed = x;
        mask = 32'hffff_ffff;
        half = 32'h0000_0000;
        unique case (fmt)
            DOF_FMT_TRUNC8: mask = 32'hff00_0000;
            DOF_FMT_ROUND16: begin mask = 32'hffff_0000; half = 32'h0000_8000; end
            DOF_FMT_ROUND24: begin mask = 32'hffff_ff00; half = 32'h0000_0080; end
            default: mask = 32'hffff_ffff;
        endcase
        sum = {x[31], x} + {1'b0, half};
        if (sum[32] != sum[31])
            fmtFixed = 32'h7fff_ffff & mask; // Rounding overflow saturates to full scale.
        else
            fmtFixed = sum[31:0] & mask;
    endfunction

    // Converts a sample to exponent and mantissa: {e, m}.
    function automatic logic [11:0] fmtFloat(input logic [31:0] x);
        logic [3:0] n;
        logic [31:0] y;
        logic stop;
        n = 4'h0;
        stop = 1'b0;
        for (int i = 30; i >= 16; i--)
        begin
            if (!stop && x[i] == x[31])
                n = n + 4'h1;
            else
                stop = 1'b1;
        end
        y = x << n;
        fmtFloat = {DOF_EXP_MAX - n, y[31:24]};
    endfunction

    // Word length per component for the selected format.
    function automatic logic [6:0] compLen(input logic [2:0] fmt);
        unique case (fmt)
            DOF_FMT_TRUNC8: compLen = DOF_LEN_8;
            DOF_FMT_ROUND16: compLen = DOF_LEN_16;
            DOF_FMT_ROUND24: compLen = DOF_LEN_24;
            DOF_FMT_FLOAT: compLen = DOF_LEN_FLOAT;
            default: compLen = DOF_LEN_32;
        endcase
    endfunction

    // Formatted components, float segments and serial pairs.
    logic isFloat;
    logic joined;
    logic [6:0] len;
    logic [31:0] fIa, fQa, fIb, fQb;
    logic [11:0] eIa, eQa, eIb, eQb;
    logic [63:0] pairA, pairB;
    logic [7:0] ratioM1;
    logic [7:0] half;
    logic launch;

    assign isFloat = s.cfg.format == DOF_FMT_FLOAT;
    assign joined = s.cfg.packed_ || isFloat;
    assign len = compLen(s.cfg.format);
    assign eIa = fmtFloat(sampleIn.ia);
    assign eQa = fmtFloat(sampleIn.qa);
    assign eIb = fmtFloat(sampleIn.ib);
    assign eQb = fmtFloat(sampleIn.qb);
    // Float I carries mantissa then exponent, Q exponent then mantissa.
    assign fIa = isFloat ? {eIa[7:0], eIa[11:8], 20'h0_0000} : fmtFixed(sampleIn.ia, s.cfg.format);
    assign fQa = isFloat ? {eQa[11:8], eQa[7:0], 20'h0_0000} : fmtFixed(sampleIn.qa, s.cfg.format);
    assign fIb = isFloat ? {eIb[7:0], eIb[11:8], 20'h0_0000} : fmtFixed(sampleIn.ib, s.cfg.format);
    assign fQb = isFloat ? {eQb[11:8], eQb[7:0], 20'h0_0000} : fmtFixed(sampleIn.qb, s.cfg.format);
    // I bits first, Q bits straight after them.
    assign pairA = {fIa, 32'h0000_0000} | ({fQa, 32'h0000_0000} >> len);
    assign pairB = {fIb, 32'h0000_0000} | ({fQb, 32'h0000_0000} >> len);
    // Bit period is divider plus one clocks; a zero divider is served as two.
    assign ratioM1 = (s.cfg.divider == 8'h00) ? 8'h01 : s.cfg.divider;
    assign half = 8'((9'(ratioM1) + 9'h001) >> 1);
    assign launch = s.phaseCnt == ratioM1;

    // Next-state logic of the whole formatter.
    always_comb
    begin
        next_s = s;
        next_s.rdData = 16'h0000;
        // Register writes.
        if (regWrite)
        begin
            unique case (regAddr)
                DOF_REG_CTRL:
                begin
                    next_s.cfg.serialEnable = regWrData[DOF_CTRL_SERIAL_EN];
                    next_s.cfg.clkPol = regWrData[DOF_CTRL_CLK_POL];
                    next_s.cfg.strobePol = regWrData[DOF_CTRL_STROBE_POL];
                    next_s.cfg.periodPol = regWrData[DOF_CTRL_PERIOD_POL];
                    next_s.cfg.muxMode = regWrData[DOF_CTRL_MUX];
                    next_s.cfg.packed_ = regWrData[DOF_CTRL_PACKED];
                end
                DOF_REG_FORMAT: next_s.cfg.format = regWrData[2:0];
                DOF_REG_DIVIDER: next_s.cfg.divider = regWrData[7:0];
                default: next_s.cfg = s.cfg;
            endcase
        end
        // Register reads; a status read clears the overrun flag.
        if (regRead)
        begin
            unique case (regAddr)
                DOF_REG_CTRL: next_s.rdData = {10'h000, s.cfg.packed_, s.cfg.muxMode, s.cfg.periodPol,
                    s.cfg.strobePol, s.cfg.clkPol, s.cfg.serialEnable};
                DOF_REG_FORMAT: next_s.rdData = {13'h0000, s.cfg.format};
                DOF_REG_DIVIDER: next_s.rdData = {8'h00, s.cfg.divider};
                DOF_REG_STATUS: next_s.rdData = {14'h0000, s.overrun, s.phase != DOF_IDLE};
                default: next_s.rdData = 16'h0000;
            endcase
            if (regAddr == DOF_REG_STATUS)
                next_s.overrun = 1'b0;
        end
        // Latch parallel segments once per period.
        if (sampleValid)
        begin
            next_s.seg[0] = isFloat ? {4'h0, eIa} : fIa[31:16];
            next_s.seg[1] = isFloat ? 16'h0000 : fIa[15:0];
            next_s.seg[2] = isFloat ? {4'h0, eQa} : fQa[31:16];
            next_s.seg[3] = isFloat ? 16'h0000 : fQa[15:0];
            next_s.seg[4] = isFloat ? {4'h0, eIb} : fIb[31:16];
            next_s.seg[5] = isFloat ? 16'h0000 : fIb[15:0];
            next_s.seg[6] = isFloat ? {4'h0, eQb} : fQb[31:16];
            next_s.seg[7] = isFloat ? 16'h0000 : fQb[15:0];
        end
        next_s.parOut = s.seg[parallelSegmentSelect];
        // Serial engine: strobe bit then word bits, one per bit period.
        unique case (s.phase)
            DOF_IDLE:
            begin
                if (sampleValid)
                begin
                    next_s.phase = DOF_STROBE;
                    next_s.phaseCnt = 8'h00;
                    next_s.firstWord = 1'b1;
                    next_s.wordLen = joined ? 7'(len << 1) : len;
                    // Words after the first: 1 unpacked, 0 packed; multiplexed, 3 unpacked, 1 packed.
                    if (s.cfg.muxMode)
                        next_s.wordsLeft = joined ? 2'h1 : 2'h3;
                    else
                        next_s.wordsLeft = joined ? 2'h0 : 2'h1;
                    // Multiplexed mode puts channel B right behind channel A.
                    next_s.shiftOne = s.cfg.muxMode ? ({pairA, 64'h0} | ({pairB, 64'h0} >> (len << 1)))
                        : {pairA, 64'h0};
                    next_s.shiftTwo = s.cfg.muxMode ? 64'h0 : pairB;
                end
            end
            DOF_STROBE:
            begin
                next_s.phaseCnt = launch ? 8'h00 : s.phaseCnt + 8'h01;
                if (launch)
                begin
                    next_s.phase = DOF_DATA;
                    next_s.firstWord = 1'b0;
                    next_s.bitCnt = s.wordLen - 7'h01;
                end
            end
            DOF_DATA:
            begin
                next_s.phaseCnt = launch ? 8'h00 : s.phaseCnt + 8'h01;
                if (launch && s.bitCnt != 7'h00)
                    next_s.bitCnt = s.bitCnt - 7'h01;
                else if (launch && s.wordsLeft != 2'h0)
                begin
                    next_s.phase = DOF_STROBE;
                    next_s.wordsLeft = s.wordsLeft - 2'h1;
                end
                else if (launch)
                    next_s.phase = DOF_IDLE;
            end
            default: next_s.phase = DOF_IDLE;
        endcase
        // A sample arriving mid-transfer is not sent serially.
        if (sampleValid && s.phase != DOF_IDLE)
            next_s.overrun = 1'b1;
        // Data shifts out MSB first at each launch into a data bit.
        if (next_s.phase == DOF_DATA && (s.phase == DOF_STROBE || launch))
        begin
            next_s.lineOne = s.shiftOne[127];
            next_s.lineTwo = s.shiftTwo[63];
            next_s.shiftOne = {s.shiftOne[126:0], 1'b0};
            next_s.shiftTwo = {s.shiftTwo[62:0], 1'b0};
        end
        else if (next_s.phase != DOF_DATA)
        begin
            next_s.lineOne = 1'b0;
            next_s.lineTwo = 1'b0;
        end
        // Pin levels; the bit clock rests at its idle level between frames.
        next_s.sck = (next_s.phase == DOF_IDLE) ? next_s.cfg.clkPol
            : next_s.cfg.clkPol ^ (next_s.phaseCnt < half);
        next_s.strobe = (next_s.phase == DOF_STROBE) ^ next_s.cfg.strobePol;
        next_s.ready = (next_s.phase == DOF_STROBE && next_s.firstWord) ^ next_s.cfg.periodPol;
    end

    // State register with synchronous reset.
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            s <= '0;
            s.phase <= DOF_IDLE;
            s.cfg.format <= DOF_FORMAT_RESET;
            s.cfg.divider <= DOF_DIVIDER_RESET;
        end
        else
            s <= next_s;
    end

    // Port outputs straight from flip-flops, except parallelOe, decoded from parallelEnableN.
    assign regRdData = s.rdData;
    assign serialBitClock = s.sck;
    assign serialFrameStrobe = s.strobe;
    assign serialLineOne = s.lineOne;
    assign serialLineTwo = s.lineTwo;
    assign serialPortOe = s.cfg.serialEnable;
    assign outputSamplePeriod = s.ready;
    assign parallelData = s.parOut;
    assign parallelOe = ~parallelEnableN;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // Checks that guard the port behaviour.
    sequence startSeq;
        sampleValid && s.phase == DOF_IDLE;
    endsequence
    sequence strobeOn;
        serialFrameStrobe != s.cfg.strobePol;
    endsequence
    sequence laterStrobe;
        s.phase == DOF_STROBE && !s.firstWord;
    endsequence

    serial_tristate_a: assert property ($rose(serialPortOe) |-> $past(regWrite) && $past(regAddr) == DOF_REG_CTRL)
        else $error("serial pins driven without an enable write");
    clock_rest_a: assert property (s.phase == DOF_IDLE |-> serialBitClock == s.cfg.clkPol)
        else $error("bit clock toggles outside a frame");
    line_two_low_a: assert property (s.cfg.muxMode && $stable(s.cfg.muxMode) && s.phase != DOF_IDLE
        |-> !serialLineTwo)
        else $error("line two not low in multiplexed mode");
    ready_start_a: assert property (startSeq |=> strobeOn and outputSamplePeriod != s.cfg.periodPol)
        else $error("period start not marked");
    strobe_then_data_a: assert property ($fell(s.phase == DOF_STROBE) |-> s.phase == DOF_DATA)
        else $error("strobe not followed by data");
    par_enable_a: assert property (parallelOe == !parallelEnableN)
        else $error("parallel enable mismatch");
    seg_hold_a: assert property (!sampleValid |=> $stable(s.seg))
        else $error("segments changed mid period");
    float_lower_a: assert property (sampleValid && isFloat |=> s.seg[1] == 16'h0000 && s.seg[7] == 16'h0000)
        else $error("float lower segment not zero");
    par_data_a: assert property (1'b1 |=> parallelData == $past(s.seg[parallelSegmentSelect]))
        else $error("parallel data not the selected segment");

    // Checks on later words, the float word count, idle lines and the overrun flag.
    ready_first_only_a: assert property (laterStrobe |-> outputSamplePeriod == s.cfg.periodPol)
        else $error("sample ready shown on a later word");

    float_packed_a: assert property (startSeq and isFloat |=> s.wordsLeft == {1'b0, s.cfg.muxMode})
        else $error("float frame not packed");

    idle_lines_a: assert property (s.phase == DOF_IDLE |-> !serialLineOne && !serialLineTwo)
        else $error("serial lines busy outside a frame");

    overrun_flag_a: assert property (sampleValid && s.phase != DOF_IDLE |=> s.overrun)
        else $error("sample during a frame not flagged");

endmodule

// *** dv/dof_serial_receiver.sv ***
// Behavioural receiver that captures the serial frames of the formatter.
`timescale 1ns/1ps

module dof_serial_receiver
(
    // Serial pins.
    input wire logic sck,
    input wire logic frameStrobe,
    input wire logic lineOne,
    input wire logic lineTwo,
    // Settings and clear.
    input wire logic clkPol,
    input wire logic strobePol,
    input wire logic clear,
    // Captured data.
    output logic [127:0] wordOne,
    output logic [127:0] wordTwo,
    output int strobeCnt,
    output int bitCnt
);
    // Captures on the edge opposite the launch edge, so the lines have settled.
    always @(sck or posedge clear)
    begin
        if (clear)
        begin
            wordOne = '0;
            wordTwo = '0;
            strobeCnt = 0;
            bitCnt = 0;
        end
        else if (sck === clkPol)
        begin
            if (frameStrobe === !strobePol)
                strobeCnt++;
            else
            begin
                wordOne = {wordOne[126:0], lineOne};
                wordTwo = {wordTwo[126:0], lineTwo};
                bitCnt++;
            end
        end
    end
endmodule

// *** dv/tb_dof_output_formatter.sv ***
// Self-checking bench of the output formatter with a serial receiver model.
`timescale 1ns/1ps

module tb_dof_output_formatter
    import dof_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] regAddr = 3'h0;
    logic [15:0] regWrData = 16'h0000;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [15:0] regRdData;
    logic sampleValid = 1'b0;
    dof_sample_s sampleIn = '0;
    logic serialBitClock, serialFrameStrobe, serialLineOne, serialLineTwo, serialPortOe;
    logic outputSamplePeriod, parallelOe;
    logic parallelEnableN = 1'b0;
    logic [2:0] parallelSegmentSelect = 3'h0;
    logic [15:0] parallelData, rdVal;
    logic clkPolTb = 1'b0;
    logic strobePolTb = 1'b0;
    logic rcvClear = 1'b0;
    logic [127:0] wordOne, wordTwo;
    int strobeCnt, bitCnt, gap;
    int error_cnt = 0;
    int total_checks = 0;
    int cycCnt = 0;

    dof_output_formatter DUT (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
        .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData), .sampleValid(sampleValid),
        .sampleIn(sampleIn), .serialBitClock(serialBitClock), .serialFrameStrobe(serialFrameStrobe),
        .serialLineOne(serialLineOne), .serialLineTwo(serialLineTwo), .serialPortOe(serialPortOe),
        .outputSamplePeriod(outputSamplePeriod), .parallelEnableN(parallelEnableN),
        .parallelSegmentSelect(parallelSegmentSelect), .parallelData(parallelData), .parallelOe(parallelOe));

    dof_serial_receiver rcv (.sck(serialBitClock), .frameStrobe(serialFrameStrobe), .lineOne(serialLineOne),
        .lineTwo(serialLineTwo), .clkPol(clkPolTb), .strobePol(strobePolTb), .clear(rcvClear),
        .wordOne(wordOne), .wordTwo(wordTwo), .strobeCnt(strobeCnt), .bitCnt(bitCnt));

    // Clock of 40 ns period.
    always #20 sys_clk = ~sys_clk;

    // Cuts a hang short well beyond the expected run length.
    always @(posedge sys_clk)
    begin
        cycCnt++;
        if (cycCnt == 20000)
        begin
            error_cnt++;
            $display("[ERR] timeout expected finish seen hang");
            close_out();
        end
    end

    // Counts one comparison and reports a mismatch.
    task automatic chk(input string name, input logic [127:0] exp, input logic [127:0] got);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle register write.
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask

    // One-cycle register read; data is taken in the cycle after the strobe.
    task automatic rd(input logic [2:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge sys_clk);
        regRead <= 1'b0;
        #1;
        d = regRdData;
    endtask

    // Programs the port and clears the receiver once the bit clock has settled.
    task automatic cfg(input logic [15:0] ctrl, input logic [2:0] fmt, input logic [7:0] div);
        wr(DOF_REG_CTRL, ctrl);
        wr(DOF_REG_FORMAT, {13'h0000, fmt});
        wr(DOF_REG_DIVIDER, {8'h00, div});
        clkPolTb = ctrl[DOF_CTRL_CLK_POL];
        strobePolTb = ctrl[DOF_CTRL_STROBE_POL];
        @(posedge sys_clk);
        #1;
        rcvClear = 1'b1;
        #1;
        rcvClear = 1'b0;
    endtask

    // Hands one sample to the formatter.
    task automatic send(input dof_sample_s s);
        @(posedge sys_clk);
        sampleValid <= 1'b1;
        sampleIn <= s;
        @(posedge sys_clk);
        sampleValid <= 1'b0;
        #1;
    endtask

    // Waits for n captured bits, measuring the bit period, then checks the clock rests.
    task automatic waitBits(input int n, output int g);
        int c;
        int last;
        int moves;
        logic prev;
        last = 0;
        moves = 0;
        prev = serialBitClock;
        g = 0;
        for (c = 1; c < 2000 && bitCnt < n; c++)
        begin
            @(posedge sys_clk);
            #1;
            if (serialBitClock !== prev && serialBitClock === !clkPolTb)
            begin
                g = c - last;
                last = c;
            end
            prev = serialBitClock;
        end
        chk("bit count", n, bitCnt);
        repeat (20)
        begin
            @(posedge sys_clk);
            #1;
            if (serialBitClock !== clkPolTb)
                moves++;
        end
        chk("resting clock moves", 0, moves);
    endtask

    // Selects one parallel segment and compares it.
    task automatic seg(input logic [2:0] i, input logic [15:0] e);
        @(posedge sys_clk);
        parallelSegmentSelect <= i;
        @(posedge sys_clk);
        #1;
        chk("parallel segment", e, parallelData);
    endtask

    // Reset values, unmapped read and output enables.
    task automatic testReset();
        chk("serial oe at reset", 0, serialPortOe);
        rd(DOF_REG_CTRL, rdVal);
        chk("ctrl reset", 16'h0000, rdVal);
        rd(DOF_REG_DIVIDER, rdVal);
        chk("divider reset", 16'h0001, rdVal);
        rd(3'h5, rdVal);
        chk("unmapped read", 16'h0000, rdVal);
        chk("parallel oe", 1, parallelOe);
        @(posedge sys_clk);
        parallelEnableN <= 1'b1;
        #1;
        chk("parallel oe off", 0, parallelOe);
        @(posedge sys_clk);
        parallelEnableN <= 1'b0;
        $display("test reset done");
    endtask

    // Split lines, 8-bit unpacked, ratio 4, with a refused sample mid-frame.
    task automatic testSplit();
        cfg(16'h0001, DOF_FMT_TRUNC8, 8'h03);
        chk("serial oe enabled", 1, serialPortOe);
        send('{32'hA512_3456, 32'h3C00_0000, 32'h0F00_0000, 32'hC300_0000});
        chk("ready at period start", 1, outputSamplePeriod);
        chk("strobe at frame start", 1, serialFrameStrobe);
        repeat (5) @(posedge sys_clk);
        send('{32'h1100_0000, 32'h2200_0000, 32'h3300_0000, 32'h4400_0000});
        waitBits(16, gap);
        chk("bit period", 4, gap);
        chk("strobes", 2, strobeCnt);
        chk("line one", 16'hA53C, wordOne);
        chk("line two", 16'h0FC3, wordTwo);
        rd(DOF_REG_STATUS, rdVal);
        chk("overrun set", 1, rdVal[DOF_STAT_OVERRUN]);
        rd(DOF_REG_STATUS, rdVal);
        chk("overrun cleared", 0, rdVal[DOF_STAT_OVERRUN]);
        $display("test split done");
    endtask

    // Multiplexed packed 16-bit words with every polarity inverted.
    task automatic testPackedMux();
        cfg(16'h003F, DOF_FMT_ROUND16, 8'h01);
        send('{32'h1234_0000, 32'h5678_0000, 32'h9ABC_0000, 32'hDEF0_0000});
        chk("ready active low", 0, outputSamplePeriod);
        chk("strobe active low", 0, serialFrameStrobe);
        waitBits(64, gap);
        chk("bit period", 2, gap);
        chk("strobes", 2, strobeCnt);
        chk("line one", 64'h1234_5678_9ABC_DEF0, wordOne);
        chk("line two low", 0, wordTwo);
        // Multiplexed unpacked: four words, each under its own strobe.
        cfg(16'h0011, DOF_FMT_TRUNC8, 8'h01);
        send('{32'hA500_0000, 32'h3C00_0000, 32'h0F00_0000, 32'hC300_0000});
        chk("ready mux unpacked", 1, outputSamplePeriod);
        waitBits(32, gap);
        chk("strobes", 4, strobeCnt);
        chk("line one", 32'hA53C_0FC3, wordOne);
        chk("line two low", 0, wordTwo);
        $display("test packed mux done");
    endtask

    // Floating words on both lines and their parallel segments.
    task automatic testFloat();
        logic [15:0] tab [0:7];
        tab = '{16'h0F40, 16'h0000, 16'h0E40, 16'h0000, 16'h0D40, 16'h0000, 16'h0C40, 16'h0000};
        cfg(16'h0001, DOF_FMT_FLOAT, 8'h01);
        send('{32'h4000_0000, 32'h2000_0000, 32'h1000_0000, 32'h0800_0000});
        waitBits(24, gap);
        chk("strobes", 1, strobeCnt);
        chk("line one", 24'h40FE40, wordOne);
        chk("line two", 24'h40DC40, wordTwo);
        for (int i = 0; i < 8; i++)
            seg(i[2:0], tab[i]);
        $display("test float done");
    endtask

    // Fixed formats on the parallel port and segment hold.
    task automatic testParallel();
        logic [15:0] hiTab [0:3];
        logic [15:0] loTab [0:3];
        hiTab = '{16'h1200, 16'h1234, 16'h1234, 16'h1234};
        loTab = '{16'h0000, 16'h0000, 16'h5600, 16'h5600};
        for (int f = 0; f < 4; f++)
        begin
            cfg(16'h0001, f[2:0], 8'h01);
            send('{32'h1234_5600, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000});
            waitBits(16 * (f + 1), gap);
            seg(3'h0, hiTab[f]);
            seg(3'h1, loTab[f]);
        end
        @(posedge sys_clk);
        sampleIn <= '{32'h7777_7777, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
        repeat (30) @(posedge sys_clk);
        seg(3'h0, 16'h1234);
        $display("test parallel done");
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence.
    initial
    begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        testReset();
        testSplit();
        testPackedMux();
        testFloat();
        testParallel();
        close_out();
    end
endmodule
